/* File: pkg/spp_pkg.sv */
// shared constants of the serial programming port
package spp_pkg;

  // command framing: four bytes, eight bits each, msb first
  localparam int SPP_CMD_BYTES = 4;
  localparam logic [2:0] SPP_BIT_LAST = 3'h7;
  localparam logic [1:0] SPP_SLOT_OP = 2'h0;
  localparam logic [1:0] SPP_SLOT_KEY = 2'h1;
  localparam logic [1:0] SPP_SLOT_ADDR_LO = 2'h2;
  localparam logic [1:0] SPP_SLOT_DATA = 2'h3;

  // access-unlock command: operation byte and key byte
  localparam logic [7:0] SPP_UNLOCK_OP = 8'hac;
  localparam logic [7:0] SPP_UNLOCK_KEY = 8'h53;

  // values after reset
  localparam logic [7:0] SPP_TX_RESET = 8'h00;
  localparam logic [31:0] SPP_CMD_RESET = 32'h0000_0000;

  // timing: system clock rate and the programmer's entry wait
  localparam int SPP_SYS_CLK_KHZ = 50000;
  localparam int SPP_ENTRY_WAIT_MS = 20;
  localparam int SPP_ENTRY_WAIT_CYC = SPP_ENTRY_WAIT_MS * SPP_SYS_CLK_KHZ;

  // least serial clock phases, in device clock cycles
  localparam int SPP_SCK_LOW_MIN_CYC = 1;
  localparam int SPP_SCK_HIGH_MIN_CYC = 4;

  // depth of the command buffer
  localparam int SPP_BUF_DEPTH = 2;

  // port states
  typedef enum logic [1:0]
  {
    SPP_ST_IDLE,
    SPP_ST_LOCKED,
    SPP_ST_OPEN
  } spp_state_t;

endpackage : spp_pkg

/* File: pkg/spp_stream_if.sv */
`timescale 1ns/1ps
// valid/ready word stream between the port and its buffer
interface spp_stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  // side that offers words
  modport src (output valid, output data, input ready);
  // side that takes words
  modport snk (input valid, input data, output ready);
endinterface : spp_stream_if

/* File: hw/spp_fifo.sv */
`timescale 1ns/1ps
// small shift buffer: the head word always sits in entry 0, a register
module spp_fifo
  import spp_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = SPP_BUF_DEPTH
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // filling side
  spp_stream_if.snk s_in,
  // draining side
  spp_stream_if.src s_out
);

  localparam int CW = $clog2(DEPTH + 1);

  // entries and fill level
  logic [WIDTH-1:0] ent_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // handshake terms
  wire push = s_in.valid && s_in.ready;
  wire pop = s_out.valid && s_out.ready;

  // full and empty straight from the level, so back-pressure is honest
  assign s_in.ready = (cnt_r != CW'(DEPTH));
  assign s_out.valid = (cnt_r != '0);
  assign s_out.data = ent_r[0];

  // level bookkeeping
  assign cnt_nxt = (push && !pop) ? cnt_r + 1'b1 :
                   (pop && !push) ? cnt_r - 1'b1 : cnt_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // each entry shifts down on a pop and takes the new word at the tail
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_ent
      wire [WIDTH-1:0] above;
      wire [WIDTH-1:0] nxt;
      if (gi == DEPTH - 1)
      begin : g_top
        assign above = s_in.data;
      end
      else
      begin : g_mid
        assign above = ent_r[gi+1];
      end
      // with a pop the tail slot moves down by one
      assign nxt = pop ? ((push && cnt_r == CW'(gi + 1)) ? s_in.data : above)
                       : ((push && cnt_r == CW'(gi)) ? s_in.data : ent_r[gi]);
      always_ff @(posedge i_clk_sys)
      begin
        if (i_sys_rst)
          ent_r[gi] <= '0;
        else
          ent_r[gi] <= nxt;
      end
    end
  endgenerate

endmodule : spp_fifo

/* File: hw/spp_port.sv */
// Operation
// (R01) programming mode only while reset pin low
// (R02) each clock pulse moves one bit each way
// (R03) only unlock accepted until unlock received
// (R04) serial interface live as reset asserts
// (R05) programmer waits 20 ms before first command
// (R06) programmer alone supplies the serial clock
// (R07) programmer holds clock low initially
// (R08) stray clock edges count as bits
// (R09) unlock key byte echoes during third byte
// (R10) programmer re-pulses reset when echo missing
// (R11) programmer sends all four unlock bytes
// (R12) clock and data-in pins: inputs, no pull-up
// (R13) clock low >1, high >4 device cycles
// (R14) programmer drives data-in throughout
// (R15) data-out driven only after unlock received; code drives it once operation and key match
// (R16) programmer pulls data-out up until driven
// (R17) programmer sole driver of serial clock
// (R18) commands: operation, two address, one data
// (R19) each byte echoes the previous byte
// (R20) read data returned in fourth byte slot
// (R21) all bytes travel msb first
// (R22) sample on rising, change after falling edge
`timescale 1ns/1ps
module spp_port
  import spp_pkg::*;
#(
  parameter int ENTRY_WAIT_CYC = SPP_ENTRY_WAIT_CYC,
  parameter int BUF_DEPTH = SPP_BUF_DEPTH
)
(
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // programming pins (inputs asynchronous to i_clk_sys)
  input wire logic i_rst_pin_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_sck_oe,
  output logic o_mosi_oe,
  output logic o_pin_pullup_en,
  // command header and read data for the fourth slot
  output logic o_hdr_valid,
  output logic [7:0] o_hdr_op,
  output logic [15:0] o_hdr_addr,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_byte,
  // completed commands
  output logic o_cmd_valid,
  output logic [31:0] o_cmd_data,
  input wire logic i_cmd_ready,
  // status
  output logic o_prog_mode,
  output logic o_unlocked,
  output logic o_entry_done,
  output logic o_overrun
);

  localparam int WC = $clog2(ENTRY_WAIT_CYC + 1);

  // two-flop synchronisers for reset pin, clock and data-in
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  // previous synchronised clock, for edge finding
  logic sck_d_r;

  // port state
  spp_state_t state_r;
  spp_state_t state_nxt;

  // receive side
  logic [7:0] rx_sh_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] slot_r;
  logic [23:0] hdr_r;

  // transmit side
  logic [7:0] tx_sh_r;
  logic load_pend_r;
  logic [7:0] echo_r;
  logic [1:0] load_slot_r;
  logic miso_oe_r;

  // header pulse
  logic hdr_valid_r;

  // command waiting for the buffer
  logic push_valid_r;
  logic [31:0] push_data_r;
  logic overrun_r;

  // entry wait counter
  logic [WC-1:0] wait_cnt_r;

  // buffer links
  spp_stream_if #(.WIDTH(32)) cmd_in ();
  spp_stream_if #(.WIDTH(32)) cmd_out ();

  // synchronised pins; the first flop is read only by the second
  wire rst_pin_n_s = pin_s2_r[2];
  wire sck_s = pin_s2_r[1];
  wire mosi_s = pin_s2_r[0];

  // programming mode follows the reset pin held low
  wire in_mode = !rst_pin_n_s; // R01

  // edges of the serial clock as seen by the system clock
  wire sck_rise = in_mode && sck_s && !sck_d_r;
  wire sck_fall = in_mode && !sck_s && sck_d_r;

  // receive decode: byte and frame completion on a rising edge
  wire [7:0] rx_byte = {rx_sh_r[6:0], mosi_s};
  wire byte_done = sck_rise && (bit_cnt_r == SPP_BIT_LAST);
  wire frame_done = byte_done && (slot_r == SPP_SLOT_DATA);
  wire [31:0] frame = {hdr_r, rx_byte};

  // the unlock check: operation and key byte in their slots
  wire key_ok = byte_done && (slot_r == SPP_SLOT_KEY)
                && (hdr_r[7:0] == SPP_UNLOCK_OP) && (rx_byte == SPP_UNLOCK_KEY);
  wire unlock_frame = frame_done && (hdr_r[23:16] == SPP_UNLOCK_OP)
                      && (hdr_r[15:8] == SPP_UNLOCK_KEY);

  // a locked port swallows every command; an open one hands it on
  wire cmd_accept = frame_done && (state_r == SPP_ST_OPEN); // R03

  // fourth slot uses the memory byte when the user asks for it
  wire use_rd = (load_slot_r == SPP_SLOT_DATA) && i_rd_en && (state_r == SPP_ST_OPEN);
  wire [7:0] tx_load = use_rd ? i_rd_byte : echo_r; // R19 R20

  // buffer handshake
  wire push_taken = push_valid_r && cmd_in.ready;

  assign cmd_in.valid = push_valid_r;
  assign cmd_in.data = push_data_r;
  assign cmd_out.ready = i_cmd_ready;

  // synchronisers: plain two-flop chains
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      sck_d_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= {i_rst_pin_n, i_sck, i_mosi};
      pin_s2_r <= pin_s1_r;
      sck_d_r <= pin_s2_r[1];
    end
  end

  // state machine: idle outside mode, locked until unlock, then open
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SPP_ST_IDLE:
        // the shifter is live from the moment reset asserts
        if (in_mode)
          state_nxt = SPP_ST_LOCKED; // R04
      SPP_ST_LOCKED:
        if (!in_mode)
          state_nxt = SPP_ST_IDLE; // R01
        else if (unlock_frame)
          state_nxt = SPP_ST_OPEN; // R03
      SPP_ST_OPEN:
        if (!in_mode)
          state_nxt = SPP_ST_IDLE; // R01
      default:
        state_nxt = SPP_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      state_r <= SPP_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // receive shifter: every rising edge is a bit, wanted or stray,
  // so a glitch on the clock puts framing out of step until re-entry
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !in_mode)
    begin
      rx_sh_r <= SPP_TX_RESET;
      bit_cnt_r <= '0;
      slot_r <= SPP_SLOT_OP;
    end
    else if (sck_rise)
    begin
      rx_sh_r <= rx_byte; // R21 R22 R08
      bit_cnt_r <= bit_cnt_r + 1'b1; // R02
      if (byte_done)
        slot_r <= slot_r + 1'b1; // R18
    end
  end

  // header of the current command: operation and two address bytes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      hdr_r <= '0;
    else if (byte_done)
      hdr_r <= {hdr_r[15:0], rx_byte}; // R18
  end

  // header pulse once three bytes are in, before the fourth slot opens;
  // the user has the rest of that clock phase to raise i_rd_en
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      hdr_valid_r <= 1'b0;
    else
      hdr_valid_r <= byte_done && (slot_r == SPP_SLOT_ADDR_LO)
                     && (state_r == SPP_ST_OPEN); // R20
  end

  // a finished byte waits for the next falling edge to be sent back
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !in_mode)
    begin
      load_pend_r <= 1'b0;
      echo_r <= SPP_TX_RESET;
      load_slot_r <= SPP_SLOT_OP;
    end
    else if (byte_done)
    begin
      load_pend_r <= 1'b1;
      echo_r <= rx_byte; // R19
      load_slot_r <= slot_r + 1'b1;
    end
    else if (sck_fall)
      load_pend_r <= 1'b0;
  end

  // transmit shifter: changes only after a falling edge, msb on the pin
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !in_mode)
      tx_sh_r <= SPP_TX_RESET;
    else if (sck_fall)
    begin
      if (load_pend_r)
        tx_sh_r <= tx_load; // R19 R20 R09
      else
        tx_sh_r <= {tx_sh_r[6:0], 1'b0}; // R21 R22 R02
    end
  end

  // data-out drive: off after reset, on once operation and key match,
  // which lets the key echo reach the programmer during byte three
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !in_mode)
      miso_oe_r <= 1'b0; // R15
    else if (key_ok || state_r == SPP_ST_OPEN)
      miso_oe_r <= 1'b1; // R15 R09
  end

  // command hand-off; a frame arriving while one still waits is lost
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      push_valid_r <= 1'b0;
      push_data_r <= SPP_CMD_RESET;
    end
    else if (cmd_accept && !(push_valid_r && !push_taken))
    begin
      push_valid_r <= 1'b1;
      push_data_r <= frame; // R18
    end
    else if (push_taken)
      push_valid_r <= 1'b0;
  end

  // overrun flag: set wins; cleared only on leaving programming mode
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      overrun_r <= 1'b0;
    else if (cmd_accept && push_valid_r && !push_taken)
      overrun_r <= 1'b1;
    else if (!in_mode)
      overrun_r <= 1'b0;
  end

  // entry wait: tells the user when the programmer may start shifting
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !in_mode)
      wait_cnt_r <= '0;
    else if (wait_cnt_r != WC'(ENTRY_WAIT_CYC))
      wait_cnt_r <= wait_cnt_r + 1'b1; // R05
  end

  // two-entry buffer: with the hand-off register, a stalled consumer loses no command until three wait
  spp_fifo #(
    .WIDTH(32),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .s_in(cmd_in.snk),
    .s_out(cmd_out.src)
  );

  // pin outputs; clock and data-in are never driven nor pulled up
  assign o_miso = tx_sh_r[7];
  assign o_miso_oe = miso_oe_r;
  assign o_sck_oe = 1'b0; // R12
  assign o_mosi_oe = 1'b0; // R12
  assign o_pin_pullup_en = 1'b0; // R12

  // header outputs
  assign o_hdr_valid = hdr_valid_r;
  assign o_hdr_op = hdr_r[23:16];
  assign o_hdr_addr = hdr_r[15:0];

  // command stream outputs
  assign o_cmd_valid = cmd_out.valid;
  assign o_cmd_data = cmd_out.data;

  // status outputs
  assign o_prog_mode = (state_r != SPP_ST_IDLE);
  assign o_unlocked = (state_r == SPP_ST_OPEN);
  assign o_entry_done = (wait_cnt_r == WC'(ENTRY_WAIT_CYC));
  assign o_overrun = overrun_r;

endmodule : spp_port

/* File: tb/spp_port_assertions.sv */
`timescale 1ns/1ps
// watches the port's pins and status from outside
module spp_port_chk
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // pins
  input wire logic i_rst_pin_n,
  input wire logic i_sck,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_sck_oe,
  input wire logic o_mosi_oe,
  input wire logic o_pin_pullup_en,
  // stream and status
  input wire logic o_hdr_valid,
  input wire logic o_cmd_valid,
  input wire logic [31:0] o_cmd_data,
  input wire logic i_cmd_ready,
  input wire logic o_prog_mode,
  input wire logic o_unlocked
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  a_pins_input: assert property (!o_sck_oe && !o_mosi_oe && !o_pin_pullup_en)
    else $error("clock or data-in pin driven");
  // sync plus state register: five low samples are ample
  a_mode_enter: assert property ((!i_rst_pin_n)[*5] |-> o_prog_mode)
    else $error("mode not entered");
  a_mode_exit: assert property (i_rst_pin_n[*5] |-> !o_prog_mode && !o_miso_oe)
    else $error("mode kept after release");
  a_oe_in_mode: assert property (o_miso_oe |-> o_prog_mode || $past(o_prog_mode))
    else $error("data-out driven outside mode");
  a_open_drives: assert property ($rose(o_unlocked) |-> o_miso_oe)
    else $error("open without data-out drive");
  // data-out moves only a few cycles after a clock fall
  a_miso_on_fall: assert property ($changed(o_miso) && !i_rst_pin_n |-> !$past(i_sck, 2))
    else $error("data-out moved off the falling edge");
  a_cmd_hold: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_data))
    else $error("word lost while stalled");
  a_cmd_open: assert property ($rose(o_cmd_valid) |-> $past(o_unlocked, 2))
    else $error("word pushed while locked");
  a_hdr_pulse: assert property (o_hdr_valid |-> o_unlocked ##1 !o_hdr_valid)
    else $error("header while locked or too long");

  c_unlock: cover property ($rose(o_unlocked));
  c_pop: cover property (o_cmd_valid && i_cmd_ready);
  c_hdr: cover property (o_hdr_valid);
endmodule : spp_port_chk

/* File: tb/spp_prog_model.sv */
`timescale 1ns/1ps
// programmer: owns reset pin, serial clock and data-in, pulls data-out up
module spp_prog_model #(parameter int WAIT_NS = 1000)
(
  // pins seen from the programmer
  output logic o_rst_pin_n,
  output logic o_sck,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  // undriven line reads high through our pull-up
  wire logic miso_line = i_miso_oe ? i_miso : 1'b1;

  initial
  begin
    o_rst_pin_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end

  // release, then hold low, then idle clock through the entry wait
  // pins move by non-blocking assignment on clock-aligned times, so the
  // device's first sync flop always sees them one edge later
  task automatic enter();
    o_rst_pin_n <= 1'b1;
    #1000 o_rst_pin_n <= 1'b0;
    o_sck <= 1'b0;
    #(WAIT_NS);
  endtask : enter

  task automatic leave();
    o_rst_pin_n <= 1'b1;
    #200;
  endtask : leave

  // one unwanted pulse, only when a test asks for it
  task automatic stray();
    #80 o_sck <= 1'b1;
    #100 o_sck <= 1'b0;
  endtask : stray

  // sample 10 ns after the rise: the device has set the bit 60 ns after the fall, 20 ns before the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_mosi <= tx[i];
      #80 o_sck <= 1'b1;
      #10 rx[i] = miso_line;
      #70 o_sck <= 1'b0;
    end
  endtask : xfer

  // whole four-byte frame, never cut short
  task automatic frame(input logic [31:0] c, output logic [31:0] r);
    for (int b = 3; b >= 0; b--)
      xfer(c[b*8+:8], r[b*8+:8]);
  endtask : frame
endmodule : spp_prog_model

/* File: tb/spp_port_tb.sv */
`timescale 1ns/1ps
module spp_port_tb;
  import spp_pkg::*;
  // short entry wait keeps the run brief
  localparam int WAIT_CYC = 50;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_rd_en = 1'b0;
  logic [7:0] i_rd_byte = 8'h00;
  logic i_cmd_ready = 1'b0;
  wire logic i_rst_pin_n, i_sck, i_mosi;
  logic o_miso, o_miso_oe, o_sck_oe, o_mosi_oe, o_pin_pullup_en, o_hdr_valid;
  logic o_cmd_valid, o_prog_mode, o_unlocked, o_entry_done, o_overrun;
  logic [7:0] o_hdr_op, last;
  logic [15:0] o_hdr_addr;
  logic [31:0] o_cmd_data, rsp;
  logic [31:0] q[$];
  int miscompares = 0;
  int comparisons = 0;
  // headers seen and the command now on the link
  int hdr_seen = 0;
  logic [31:0] cur = 32'h0000_0000;

  always #10 i_clk_sys = ~i_clk_sys;

  spp_port #(.ENTRY_WAIT_CYC(WAIT_CYC)) dut_u
  (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_rst_pin_n(i_rst_pin_n),
    .i_sck(i_sck),
    .i_mosi(i_mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .o_sck_oe(o_sck_oe),
    .o_mosi_oe(o_mosi_oe),
    .o_pin_pullup_en(o_pin_pullup_en),
    .o_hdr_valid(o_hdr_valid),
    .o_hdr_op(o_hdr_op),
    .o_hdr_addr(o_hdr_addr),
    .i_rd_en(i_rd_en),
    .i_rd_byte(i_rd_byte),
    .o_cmd_valid(o_cmd_valid),
    .o_cmd_data(o_cmd_data),
    .i_cmd_ready(i_cmd_ready),
    .o_prog_mode(o_prog_mode),
    .o_unlocked(o_unlocked),
    .o_entry_done(o_entry_done),
    .o_overrun(o_overrun)
  );
  // the port starts counting only after its pin sync, so wait a few more
  spp_prog_model #(.WAIT_NS((WAIT_CYC + 4) * 20)) prog_u
  (
    .o_rst_pin_n(i_rst_pin_n),
    .o_sck(i_sck),
    .o_mosi(i_mosi),
    .i_miso(o_miso),
    .i_miso_oe(o_miso_oe)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // previous byte echoed; last slot carries the read byte when asked
  function automatic logic [31:0] reply(logic [31:0] c, logic [7:0] p, logic rd, logic [7:0] rb);
    return {p, c[31:16], rd ? rb : c[15:8]};
  endfunction : reply

  // one open-state command with a random read request
  task automatic send(input logic [31:0] c);
    logic rd;
    rd = 1'($urandom);
    @(posedge i_clk_sys);
    i_rd_en <= rd;
    i_rd_byte <= 8'($urandom);
    @(posedge i_clk_sys);
    cur = c;
    prog_u.frame(c, rsp);
    chk(rsp, reply(c, last, rd, i_rd_byte), "reply");
    last = c[7:0];
    q.push_back(c);
  endtask : send

  // head word checked, then taken with a one-cycle ready
  task automatic pop();
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_cmd_data, q.pop_front(), "word");
    @(posedge i_clk_sys);
    i_cmd_ready <= 1'b1;
    @(posedge i_clk_sys);
    i_cmd_ready <= 1'b0;
  endtask : pop

  // header fields stand only until byte four ends, so look mid-frame
  always @(negedge i_clk_sys)
    if (o_hdr_valid === 1'b1)
    begin
      hdr_seen++;
      chk({o_hdr_op, o_hdr_addr}, cur[31:8], "header");
    end

  // cut a hang short
  initial
  begin
    #200000 miscompares++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(17914));
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    // a stray edge puts framing out of step: unlock fails
    prog_u.enter();
    prog_u.stray();
    prog_u.frame({SPP_UNLOCK_OP, SPP_UNLOCK_KEY, 16'h1234}, rsp);
    chk(rsp[15:8], 8'hff, "key echo");
    chk(o_miso_oe, 1'b0, "locked oe");
    chk(o_prog_mode, 1'b1, "mode");
    $display("test stray done");
    // fresh entry, unlock in step
    prog_u.enter();
    chk(o_entry_done, 1'b1, "entry wait");
    prog_u.frame({SPP_UNLOCK_OP, SPP_UNLOCK_KEY, 16'hc35a}, rsp);
    chk(rsp, {16'hffff, SPP_UNLOCK_KEY, 8'hc3}, "unlock reply");
    chk(o_unlocked, 1'b1, "unlocked");
    last = 8'h5a;
    $display("test unlock done");
    // stalled consumer: three words held, the fourth lost
    for (int k = 0; k < 4; k++)
    begin
      send($urandom);
      chk(o_overrun, k == 3, "overrun");
    end
    void'(q.pop_back());
    repeat (3) pop();
    #1 chk(o_cmd_valid, 1'b0, "drained");
    for (int k = 0; k < 8; k++)
    begin
      send($urandom);
      pop();
    end
    $display("test stream done");
    // release leaves the mode; re-entry is locked again
    prog_u.leave();
    chk({o_prog_mode, o_unlocked, o_miso_oe}, 3'h0, "left");
    chk(o_entry_done, 1'b0, "entry cleared");
    prog_u.enter();
    prog_u.frame(32'h3000_0000, rsp);
    chk(rsp, 32'hffff_ffff, "locked reply");
    repeat (4) @(posedge i_clk_sys);
    #1 chk({o_cmd_valid, o_miso_oe}, 2'h0, "relocked");
    chk(hdr_seen, 32'd12, "headers");
    $display("test relock done");
    wrap_up();
  end
endmodule : spp_port_tb

bind spp_port spp_port_chk chk_u
(
  .i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst),
  .i_rst_pin_n(i_rst_pin_n),
  .i_sck(i_sck),
  .o_miso(o_miso),
  .o_miso_oe(o_miso_oe),
  .o_sck_oe(o_sck_oe),
  .o_mosi_oe(o_mosi_oe),
  .o_pin_pullup_en(o_pin_pullup_en),
  .o_hdr_valid(o_hdr_valid),
  .o_cmd_valid(o_cmd_valid),
  .o_cmd_data(o_cmd_data),
  .i_cmd_ready(i_cmd_ready),
  .o_prog_mode(o_prog_mode),
  .o_unlocked(o_unlocked)
);
